// >>> src/protection_timer_select.sv
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
// How it works
// - area timer codes map 0..1000 ms
// - rms window of 16/128/1024/8192 samples
// - severe digital filter codes map 0..1000 ms
// - severe analog filter codes 0..1000 ns
// - gate recovery finishes within 100 us
module protection_timer_select
   import prot_timer_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
) (
   // clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        rst_in,
   input  wire logic        ce_in,
   // register port
   input  wire logic [3:0]  addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [31:0] rdata_out,
   // analog comparator pins
   input  wire logic        sev_oc_comp_in,
   input  wire logic        gate_above_4v_in,
   input  wire logic        supply_voltage_low_in,
   // same clock logic inputs
   input  wire logic        area_reg_active_in,
   input  wire logic        on_state_in,
   input  wire logic        sample_valid_in,
   input  wire logic [11:0] current_sample_in,
   // results
   output logic             severe_oc_fault_out,
   output logic             area_timeout_out,
   output logic      [23:0] rms_mean_sq_out,
   output logic             rms_window_done_out,
   output logic             recovery_busy_out,
   output logic             recovery_done_out,
   output logic             recovery_timeout_out
);
   typedef struct packed {
      logic [11:0] tick_cnt;
      logic        tick;
      logic [2:0]  area_sel;
      logic [1:0]  rms_sel;
      logic [2:0]  dig_sel;
      logic [1:0]  ana_sel;
      logic [36:0] acc;
      logic [13:0] smp_cnt;
      logic [23:0] mean_sq;
      logic        rms_done;
      logic        soc_s1;
      logic        soc_s2;
      logic        gate_s1;
      logic        gate_s2;
      logic        low_s1;
      logic        low_s2;
      logic        sev_prev;
      logic        rec_busy;
      logic        rec_done;
      logic        rec_tmo;
      logic [10:0] rec_cnt;
      logic [31:0] rdata;
   } top_state_t;

   top_state_t st_q;
   top_state_t st_d;

   filt_if #(.W(AW)) ana_if ();
   filt_if #(.W(TW)) dig_if ();
   filt_if #(.W(TW)) area_if ();

   logic [23:0] sq;
   logic [36:0] acc_sum;
   logic [36:0] acc_shift;
   logic        rec_cond;

   // analog filter runs every cycle, the long ones on the 10 us tick
   assign ana_if.cond   = st_q.soc_s2;
   assign ana_if.tick   = 1'b1;
   assign ana_if.limit  = ana_cycles(st_q.ana_sel);
   assign dig_if.cond   = ana_if.fault;
   assign dig_if.tick   = st_q.tick;
   assign dig_if.limit  = dig_ticks(st_q.dig_sel);
   assign area_if.cond  = area_reg_active_in;
   assign area_if.tick  = st_q.tick;
   assign area_if.limit = area_ticks(st_q.area_sel);

   persist_filter #(.W(AW)) u_ana (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .ce_in      (ce_in),
      .f          (ana_if.filter)
   );
   persist_filter #(.W(TW)) u_dig (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .ce_in      (ce_in),
      .f          (dig_if.filter)
   );
   persist_filter #(.W(TW)) u_area (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .ce_in      (ce_in),
      .f          (area_if.filter)
   );

   assign sq        = {12'h000, current_sample_in} *
                      {12'h000, current_sample_in};
   assign acc_sum   = st_q.acc + {13'h0000, sq};
   assign acc_shift = acc_sum >> rms_shift(st_q.rms_sel);
   // low supply waits for gate level, otherwise for the on state
   assign rec_cond  = st_q.low_s2 ? st_q.gate_s2 : on_state_in;

   always_comb begin
      st_d = st_q;
      st_d.soc_s1  = sev_oc_comp_in;
      st_d.soc_s2  = st_q.soc_s1;
      st_d.gate_s1 = gate_above_4v_in;
      st_d.gate_s2 = st_q.gate_s1;
      st_d.low_s1  = supply_voltage_low_in;
      st_d.low_s2  = st_q.low_s1;

      st_d.tick = 1'b0;
      if (st_q.tick_cnt >= 12'(TICK_CYCLES - 1)) begin
         st_d.tick_cnt = 12'h000;
         st_d.tick     = 1'b1;
      end else begin
         st_d.tick_cnt = st_q.tick_cnt + 12'h001;
      end

      // a new size is held against the running count at once
      st_d.rms_done = 1'b0;
      if (sample_valid_in) begin
         if (st_q.smp_cnt >= (14'h0001 << rms_shift(st_q.rms_sel))
                             - 14'h0001) begin
            st_d.mean_sq  = acc_shift[23:0];
            st_d.acc      = '0;
            st_d.smp_cnt  = 14'h0000;
            st_d.rms_done = 1'b1;
         end else begin
            st_d.acc     = acc_sum;
            st_d.smp_cnt = st_q.smp_cnt + 14'h0001;
         end
      end

      st_d.sev_prev = dig_if.fault;
      st_d.rec_done = 1'b0;
      if (wr_in && addr_in == STAT_OFS && wdata_in[ST_RTMO_BIT]) begin
         st_d.rec_tmo = 1'b0;
      end
      if (st_q.rec_busy) begin
         if (rec_cond) begin
            st_d.rec_busy = 1'b0;
            st_d.rec_done = 1'b1;
         end else if (st_q.rec_cnt >= 11'(REC_CYC - 1)) begin
            st_d.rec_busy = 1'b0;
            st_d.rec_tmo  = 1'b1;
         end else begin
            st_d.rec_cnt = st_q.rec_cnt + 11'h001;
         end
      end
      if (st_q.sev_prev && !dig_if.fault) begin
         st_d.rec_busy = 1'b1;
         st_d.rec_cnt  = 11'h000;
      end

      if (wr_in && addr_in == CFG_OFS) begin
         st_d.area_sel = wdata_in[AREA_SEL_LSB +: 3];
         st_d.rms_sel  = wdata_in[RMS_SEL_LSB +: 2];
         st_d.dig_sel  = wdata_in[DIG_SEL_LSB +: 3];
         st_d.ana_sel  = wdata_in[ANA_SEL_LSB +: 2];
      end

      st_d.rdata = 32'h0000_0000;
      if (rd_in) begin
         case (addr_in)
            CFG_OFS: begin
               st_d.rdata[AREA_SEL_LSB +: 3] = st_q.area_sel;
               st_d.rdata[RMS_SEL_LSB +: 2]  = st_q.rms_sel;
               st_d.rdata[DIG_SEL_LSB +: 3]  = st_q.dig_sel;
               st_d.rdata[ANA_SEL_LSB +: 2]  = st_q.ana_sel;
            end
            STAT_OFS: begin
               st_d.rdata[ST_SEV_BIT]   = dig_if.fault;
               st_d.rdata[ST_AREA_BIT]  = area_if.fault;
               st_d.rdata[ST_RBUSY_BIT] = st_q.rec_busy;
               st_d.rdata[ST_RDONE_BIT] = st_q.rec_done;
               st_d.rdata[ST_RTMO_BIT]  = st_q.rec_tmo;
            end
            RMS_OFS: begin
               st_d.rdata[23:0] = st_q.mean_sq;
            end
            default: begin
               st_d.rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_q          <= '0;
         st_q.area_sel <= CFG_RST[AREA_SEL_LSB +: 3];
         st_q.rms_sel  <= CFG_RST[RMS_SEL_LSB +: 2];
         st_q.dig_sel  <= CFG_RST[DIG_SEL_LSB +: 3];
         st_q.ana_sel  <= CFG_RST[ANA_SEL_LSB +: 2];
      end else if (ce_in) begin
         st_q <= st_d;
      end
   end

   assign rdata_out            = st_q.rdata;
   assign severe_oc_fault_out  = dig_if.fault;
   assign area_timeout_out     = area_if.fault;
   assign rms_mean_sq_out      = st_q.mean_sq;
   assign rms_window_done_out  = st_q.rms_done;
   assign recovery_busy_out    = st_q.rec_busy;
   assign recovery_done_out    = st_q.rec_done;
   assign recovery_timeout_out = st_q.rec_tmo;

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   a_area_top_code: assert property (
      st_q.area_sel == 3'h7 |-> area_if.limit == 17'h186a0)
      else $error("area code 7 is not 1000 ms");
   a_rms_window_len: assert property (
      $rose(st_q.rms_done) |-> $past(st_q.smp_cnt) ==
      (14'h0001 << rms_shift($past(st_q.rms_sel))) - 14'h0001)
      else $error("rms window length wrong");
   a_dig_first_code: assert property (
      st_q.dig_sel == 3'h1 |-> dig_if.limit == 17'h00001)
      else $error("digital code 1 is not 10 us");
   a_ana_first_code: assert property (
      st_q.ana_sel == 2'h1 |-> ana_if.limit == 5'h04)
      else $error("analog code 1 is not 200 ns");
   a_rec_bounded: assert property (
      st_q.rec_busy |-> st_q.rec_cnt <= 11'h7cf)
      else $error("recovery ran past 100 us");
   a_rec_finishes: assert property (
      (st_q.rec_busy && rec_cond && ce_in && dig_if.fault == 1'b0
       && !(st_q.sev_prev && !dig_if.fault)) |=>
      !st_q.rec_busy && st_q.rec_done)
      else $error("recovery did not end on its condition");

   c_area_timeout: cover property ($rose(area_if.fault));
   c_rms_done:     cover property ($rose(st_q.rms_done));
   c_rec_done:     cover property ($rose(st_q.rec_done));
   c_rec_tmo:      cover property ($rose(st_q.rec_tmo));
endmodule

// >>> common/prot_timer_pkg.sv
package prot_timer_pkg;
   // register byte offsets
   localparam logic [3:0] CFG_OFS  = 4'h0;
   localparam logic [3:0] STAT_OFS = 4'h4;
   localparam logic [3:0] RMS_OFS  = 4'h8;

   // config register field positions
   localparam int AREA_SEL_LSB = 0;
   localparam int RMS_SEL_LSB  = 3;
   localparam int DIG_SEL_LSB  = 5;
   localparam int ANA_SEL_LSB  = 8;
   localparam logic [9:0] CFG_RST = 10'h000;

   // status register bit positions
   localparam int ST_SEV_BIT     = 0;
   localparam int ST_AREA_BIT    = 1;
   localparam int ST_RBUSY_BIT   = 2;
   localparam int ST_RDONE_BIT   = 3;
   localparam int ST_RTMO_BIT    = 4;

   // clock and time base
   localparam int CLK_PERIOD_NS  = 50;
   localparam int TICK_TIME_NS   = 10000;
   localparam int TICK_CYC       = TICK_TIME_NS / CLK_PERIOD_NS;
   localparam int TICKS_PER_MS   = 1000000 / TICK_TIME_NS;

   // analog filter lengths in ns, rounded up to cycles
   localparam int ANA_T1_NS = 200;
   localparam int ANA_T2_NS = 500;
   localparam int ANA_T3_NS = 1000;
   localparam int ANA_C1 = (ANA_T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ANA_C2 = (ANA_T2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ANA_C3 = (ANA_T3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // gate recovery limit, a longest time, rounded down
   localparam int REC_TIME_NS = 100000;
   localparam int REC_CYC     = REC_TIME_NS / CLK_PERIOD_NS;

   localparam int TW = 17;
   localparam int AW = 5;

   function automatic logic [TW-1:0] area_ticks(input logic [2:0] sel);
      int ms;
      ms = 0;
      case (sel)
         3'h0: ms = 0;
         3'h1: ms = 1;
         3'h2: ms = 5;
         3'h3: ms = 10;
         3'h4: ms = 50;
         3'h5: ms = 100;
         3'h6: ms = 500;
         default: ms = 1000;
      endcase
      return TW'(ms * TICKS_PER_MS);
   endfunction

   // digital filter table in units of 10 us ticks
   function automatic logic [TW-1:0] dig_ticks(input logic [2:0] sel);
      int t;
      t = 0;
      case (sel)
         3'h0: t = 0;
         3'h1: t = 1;
         3'h2: t = 10;
         3'h3: t = TICKS_PER_MS;
         3'h4: t = 10 * TICKS_PER_MS;
         3'h5: t = 100 * TICKS_PER_MS;
         3'h6: t = 500 * TICKS_PER_MS;
         default: t = 1000 * TICKS_PER_MS;
      endcase
      return TW'(t);
   endfunction

   function automatic logic [AW-1:0] ana_cycles(input logic [1:0] sel);
      int c;
      c = 0;
      case (sel)
         2'h0: c = 0;
         2'h1: c = ANA_C1;
         2'h2: c = ANA_C2;
         default: c = ANA_C3;
      endcase
      return AW'(c);
   endfunction

   function automatic logic [3:0] rms_shift(input logic [1:0] sel);
      case (sel)
         2'h0: return 4'h4;
         2'h1: return 4'h7;
         2'h2: return 4'ha;
         default: return 4'hd;
      endcase
   endfunction
endpackage

// >>> common/filt_if.sv
`timescale 1ns/100ps
interface filt_if #(parameter int W = 17);
   logic         cond;
   logic         tick;
   logic [W-1:0] limit;
   logic         fault;
   modport owner  (output cond, output tick, output limit, input fault);
   modport filter (input cond, input tick, input limit, output fault);
endinterface

// >>> src/persist_filter.sv
`timescale 1ns/100ps
module persist_filter #(
   parameter int W = 17
) (
   // clock and reset
   input  wire logic sys_clk_in,
   input  wire logic rst_in,
   input  wire logic ce_in,
   // condition and result
   filt_if.filter    f
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         fault;
   } filt_state_t;

   filt_state_t st_q;
   filt_state_t st_d;

   always_comb begin
      st_d = st_q;
      if (!f.cond) begin
         st_d.cnt   = '0;
         st_d.fault = 1'b0;
      end else if (f.limit == '0) begin
         st_d.fault = 1'b1;
      end else if (f.tick && !st_q.fault) begin
         // counting only while the condition holds without a break
         if (st_q.cnt >= f.limit - W'(1)) begin
            st_d.fault = 1'b1;
         end else begin
            st_d.cnt = st_q.cnt + W'(1);
         end
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_q <= '0;
      end else if (ce_in) begin
         st_q <= st_d;
      end
   end

   assign f.fault = st_q.fault;

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   a_drop_clears: assert property ((!f.cond && ce_in) |=> !st_q.fault)
      else $error("fault kept after condition dropped");
   a_zero_passes: assert property (
      (f.cond && f.limit == '0 && ce_in) |=> st_q.fault)
      else $error("zero length did not pass condition");
   a_rise_needs_hold: assert property (
      $rose(st_q.fault) && $past(f.limit) != '0 |-> $past(st_q.cnt)
      >= $past(f.limit) - W'(1))
      else $error("fault rose before full duration");
endmodule

// >>> verification/fet_partner.sv
`timescale 1ns/100ps
module fet_partner (
   // clock and reset
   input  wire logic        sys_clk_in,
   input  wire logic        rst_in,
   // bench controls
   input  wire logic        oc_req_in,
   input  wire logic        low_supply_in,
   input  wire logic [11:0] delay_in,
   // device side
   input  wire logic        fault_in,
   output logic             comp_out,
   output logic             gate_out,
   output logic             low_out,
   output logic             on_out
);
   logic [11:0] cnt_q;

   // gate only charges once the fault has let go
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_q <= 12'h000;
      end else if (fault_in) begin
         cnt_q <= 12'h000;
      end else if (cnt_q != 12'hfff) begin
         cnt_q <= cnt_q + 12'h001;
      end
   end

   assign comp_out = oc_req_in;
   assign low_out  = low_supply_in;
   // the two completion signs differ, so a wrong choice shows up
   assign gate_out = low_supply_in ? (cnt_q >= delay_in)
                                   : (cnt_q != 12'h000);
   assign on_out   = !low_supply_in && (cnt_q >= delay_in);
endmodule

// >>> verification/testbench.sv
`timescale 1ns/100ps
module testbench;
   import prot_timer_pkg::*;
   localparam int TK  = 4;
   localparam int REC = 100000 / 50;
   localparam int AREA_MS[8] = '{0, 1, 5, 10, 50, 100, 500, 1000};
   // digital steps of 10 us
   localparam int DIG_T[5] = '{0, 1, 10, 100, 1000};
   localparam int ANA_NS[4] = '{0, 200, 500, 1000};
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic [31:0] rv;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        ce = 1'b1;
   logic        oc_req = 1'b0;
   logic        low_sup = 1'b0;
   logic        area_act = 1'b0;
   logic        sv = 1'b0;
   logic [11:0] dly = 12'h010;
   logic [11:0] smp = 12'h000;
   logic        comp, gate, low, on_st, fault, area_to;
   logic        rdone, rbusy, rok, rtmo;
   logic [23:0] msq;
   logic [15:0] rnd = 16'hd684;
   logic [35:0] acc;
   int          fail_count = 0;
   int          cmp_count = 0;
   int          lat, c, t, n, i;

   always #25 clk = ~clk;

   protection_timer_select #(.TICK_CYCLES(TK)) protection_timer_select_inst (
      .sys_clk_in(clk), .rst_in(rst), .ce_in(ce), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
      .sev_oc_comp_in(comp), .gate_above_4v_in(gate),
      .supply_voltage_low_in(low), .area_reg_active_in(area_act),
      .on_state_in(on_st), .sample_valid_in(sv), .current_sample_in(smp),
      .severe_oc_fault_out(fault), .area_timeout_out(area_to),
      .rms_mean_sq_out(msq), .rms_window_done_out(rdone),
      .recovery_busy_out(rbusy), .recovery_done_out(rok),
      .recovery_timeout_out(rtmo));

   fet_partner fet_partner_inst (
      .sys_clk_in(clk), .rst_in(rst), .oc_req_in(oc_req),
      .low_supply_in(low_sup), .delay_in(dly), .fault_in(fault),
      .comp_out(comp), .gate_out(gate), .low_out(low), .on_out(on_st));

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic logic pick(input int w);
      case (w)
         0: return fault;
         1: return area_to;
         2: return rdone;
         3: return rtmo;
         default: return rok;
      endcase
   endfunction

   task automatic conclude();
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check_val(input string nm, input logic [35:0] e, g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic check_rng(input string nm, input int lo, hi, g);
      cmp_count++;
      if (g < lo || g > hi) begin
         fail_count++;
         $display("wrong value %s exp %0d..%0d got %0d", nm, lo, hi, g);
      end
   endtask

   // counts edges until the output reaches lv or the bound; with must set, a timeout ends the run
   task automatic wait_for(input int w, input logic lv, input int bnd,
                           input bit must, output int k);
      k = 0;
      do begin
         @(posedge clk);
         #1;
         k++;
      end while (pick(w) !== lv && k < bnd);
      if (must && pick(w) !== lv) begin
         fail_count++;
         $display("wrong value wait %0d exp %0d got timeout", w, lv);
         conclude();
      end
   endtask

   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic sev_meas(input logic [31:0] cfg, input int lo, hi);
      bus_wr(CFG_OFS, cfg);
      @(posedge clk);
      oc_req <= 1'b1;
      wait_for(0, 1'b1, hi + 5, 1'b1, lat);
      check_rng("severe latency", lo, hi, lat);
      @(posedge clk);
      oc_req <= 1'b0;
      wait_for(0, 1'b0, 20, 1'b1, lat);
   endtask

   task automatic recov(input logic ls, input logic [11:0] d,
                        input int w, lo, hi);
      @(posedge clk);
      low_sup <= ls;
      dly <= d;
      oc_req <= 1'b1;
      wait_for(0, 1'b1, 20, 1'b1, lat);
      @(posedge clk);
      oc_req <= 1'b0;
      wait_for(0, 1'b0, 20, 1'b1, lat);
      @(posedge clk);
      #1 check_val("recovery busy", 36'h1, rbusy);
      wait_for(w, 1'b1, hi + 5, 1'b1, lat);
      check_rng("recovery time", lo, hi, lat);
   endtask

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      bus_rd(CFG_OFS, rv);
      check_val("config reset", 36'h0, rv);
      bus_wr(CFG_OFS, 32'hffff_ffff);
      bus_rd(CFG_OFS, rv);
      check_val("config fields", 36'h3ff, rv);
      bus_wr(RMS_OFS, 32'h00ab_cdef);
      bus_rd(RMS_OFS, rv);
      check_val("rms read only", 36'h0, rv);
      bus_rd(4'hc, rv);
      check_val("unmapped", 36'h0, rv);
      for (c = 0; c < 5; c++) begin
         t = DIG_T[c];
         sev_meas(32'(c) << DIG_SEL_LSB, t == 0 ? 4 : 3 + (t - 1) * TK,
                  t == 0 ? 4 : 5 + (t + 1) * TK);
      end
      for (c = 1; c < 4; c++) begin
         n = ANA_NS[c] / 50;
         bus_wr(CFG_OFS, 32'(c) << ANA_SEL_LSB);
         @(posedge clk);
         oc_req <= 1'b1;
         repeat (n - 1) @(posedge clk);
         oc_req <= 1'b0;
         wait_for(0, 1'b1, n + 6, 1'b0, lat);
         check_rng("short glitch", n + 6, n + 6, lat);
         sev_meas(32'(c) << ANA_SEL_LSB, 3 + n, 5 + n);
      end
      for (c = 0; c < 4; c++) begin
         t = AREA_MS[c] * 100;
         bus_wr(CFG_OFS, 32'(c) << AREA_SEL_LSB);
         @(posedge clk);
         area_act <= 1'b1;
         wait_for(1, 1'b1, t * TK + 20, 1'b1, lat);
         check_rng("area latency", t == 0 ? 1 : (t - 1) * TK,
                   t == 0 ? 1 : (t + 1) * TK + 2, lat);
         @(posedge clk);
         area_act <= 1'b0;
         wait_for(1, 1'b0, 20, 1'b1, lat);
      end
      for (c = 0; c < 2; c++) begin
         n = 16 << (3 * c);
         acc = 36'h0;
         bus_wr(CFG_OFS, 32'(c) << RMS_SEL_LSB);
         // back to back strobes, first one at full scale
         for (i = 0; i < n; i++) begin
            @(posedge clk);
            sv <= 1'b1;
            smp <= (i == 0) ? 12'hfff : rnd[11:0];
            acc = acc + ((i == 0) ? 36'hffe001
                         : 36'(rnd[11:0]) * 36'(rnd[11:0]));
            rnd = lfsr(rnd);
         end
         @(posedge clk);
         sv <= 1'b0;
         // the done pulse stands only until the next edge
         #1 check_val("rms done", 36'h1, rdone);
         check_val("rms mean", acc >> (4 + 3 * c), msq);
         @(posedge clk);
         #1 check_val("rms done end", 36'h0, rdone);
         bus_rd(RMS_OFS, rv);
         check_val("rms register", acc >> (4 + 3 * c), rv);
      end
      bus_wr(CFG_OFS, 32'h0);
      recov(1'b0, 12'h028, 4, 36, 48);
      recov(1'b1, 12'h028, 4, 36, 48);
      recov(1'b0, 12'hbb8, 3, REC - 5, REC + 5);
      bus_rd(STAT_OFS, rv);
      check_val("timeout flag", 36'h1, rv[ST_RTMO_BIT]);
      check_val("busy after timeout", 36'h0, rv[ST_RBUSY_BIT]);
      bus_wr(STAT_OFS, 32'h1 << ST_RTMO_BIT);
      bus_rd(STAT_OFS, rv);
      check_val("timeout cleared", 36'h0, rv[ST_RTMO_BIT]);
      // a write while frozen must not be taken
      @(posedge clk);
      ce <= 1'b0;
      bus_wr(CFG_OFS, 32'h0000_03ff);
      @(posedge clk);
      ce <= 1'b1;
      bus_rd(CFG_OFS, rv);
      check_val("frozen write", 36'h0, rv);
      conclude();
   end
endmodule
